// ---- rff_cfg.svh ----
`ifndef RFF_CFG_SVH
`define RFF_CFG_SVH
// Register offsets on the plain register port.
`define RFF_REG_CTRL    5'h00
`define RFF_REG_OPT     5'h04
`define RFF_REG_VLAN    5'h08
`define RFF_REG_DUMP    5'h0c
`define RFF_REG_STATUS  5'h10
// Field positions.
`define RFF_BIT_SWRST   0
`define RFF_BIT_STP     1
`define RFF_BIT_EXTAR   2
`define RFF_BIT_XLONG   11
`define RFF_BIT_FLOOD   12
`define RFF_BIT_DROPXC  15
// Reset values.
`define RFF_RST_VLAN    24'hffffff
`define RFF_RST_DUMP    24'h000000
`define RFF_RST_PORT    5'h00
// Frame constants.
`define RFF_SFD         8'hab
`define RFF_CRC_INIT    32'hffffffff
`define RFF_CRC_POLY    32'hedb88320
`define RFF_CRC_RESID   32'hdebb20e3
`define RFF_BPDU_DA     48'h0180c2000000
`define RFF_PAUSE_DA    48'h0180c2000001
`define RFF_PAUSE_TYPE  16'h8808
`define RFF_CPU_PORT    5'h17
// Timing counts in bit times and bytes, and the excessive collision count.
`define RFF_SHORT_BT    16'h0054
`define RFF_RUNT_BT     16'h0200
`define RFF_JABBER_BT   16'hc350
`define RFF_MAX_LEN     13'h05ee
`define RFF_XMAX_LEN    13'h05fa
`define RFF_EXCESS_COL  5'h10
`endif

// ---- rff_pkg.sv ----
package rff_pkg;
  typedef enum logic [1:0] {RFF_IDLE, RFF_HUNT, RFF_BODY} rff_state_e;
  typedef struct packed {
    logic jabber;
    logic long_ev;
    logic runt;
    logic short_ev;
    logic false_car;
    logic align;
    logic crc;
  } rff_err_s;
  typedef struct packed {
    logic        da_valid;
    logic        sa_valid;
    logic        learn;
    logic [47:0] da;
    logic [47:0] sa;
  } rff_ar_req_s;
  typedef struct packed {
    logic       valid;
    logic       hit;
    logic       filter;
    logic [4:0] port;
  } rff_ar_rsp_s;
endpackage

// ---- rff_top.sv ----
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "rff_cfg.svh"
// Contract
// - Start on carrier, take dibits, serialise
// - Any-length preamble used only for sync; the hunt needs at least three preamble dibits
// - Hunt start delimiter, drop bits before it
// - Group DA floods source VLAN except source
// - Learn source address after good frame
// - Hardware reset clears table, software keeps
// - Type and payload pass untouched, except pause
// - CRC over DA through data vs check
// - CRC mismatch drops frame, pulses error
// - Far side leaves 64 bit-time gap
// - Carrier under 84 bit times: short event
// - Frame under 512 bit times: runt
// - Legal 64 to 1518 bytes, else long
// - Extra-long option raises limit to 1530
// - Error frames not forwarded, still reported
// - Destination equal to source is filtered
// - Present DA and SA, obey resolver
// - Spanning tree sends BPDU to port 23
// - Jabber over 50000 bits isolates port
// - Sixteen collisions: retry or drop
// - Unicast when DA bit 40 clear
// - Unknown unicast: flood or dumping ports
// - Keep broadcast and unicast order
module rff_top (
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Reduced MII receive pins.
  input  wire logic                 rx_clk,
  input  wire logic                 crs_dv,
  input  wire logic [1:0]           rxd,
  // Register port.
  input  wire logic [4:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // Frame data towards the frame buffer.
  output logic      [7:0]           rx_byte,
  output logic                      rx_byte_valid,
  // Statistics and forwarding.
  output logic                      stat_valid,
  output rff_pkg::rff_err_s         stat_err,
  output logic      [12:0]          stat_len,
  output logic                      fwd_valid,
  output logic      [23:0]          fwd_mask,
  output logic                      pause_seen,
  output logic                      frame_err_led,
  output logic                      jabber_iso,
  // Address resolver.
  output rff_pkg::rff_ar_req_s      ar_req,
  input  wire rff_pkg::rff_ar_rsp_s ar_rsp,
  // Transmit collision handling.
  input  wire logic                 tx_col,
  input  wire logic                 tx_done,
  output logic                      tx_retry,
  output logic                      tx_drop
);
  import rff_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and link clock edge detection.
  logic [2:0]  lclk_s;
  logic [1:0]  crs_s;
  logic [1:0]  d_s1;
  logic [1:0]  d;
  logic        link_edge;
  logic        crs;

  // Every pin passes two flops; the third clock stage only serves the edge test.
  always_ff @(posedge clock) begin
    lclk_s <= {lclk_s[1:0], rx_clk};
    crs_s  <= {crs_s[0], crs_dv};
    d_s1   <= rxd;
    d      <= d_s1;
  end
  assign link_edge = lclk_s[1] & ~lclk_s[2];
  assign crs       = crs_s[1];

  //////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic        sw_rst;
  logic        stp_en;
  logic        ext_ar;
  logic        xlong;
  logic        flood;
  logic        drop_xc;
  logic [23:0] vlan_mask;
  logic [23:0] dump_mask;
  logic [4:0]  port_id;
  logic [15:0] frame_cnt;
  rff_err_s    last_err;

  // Configuration writes; software reset bit self-clears.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sw_rst    <= 1'b0;
      stp_en    <= 1'b0;
      ext_ar    <= 1'b0;
      xlong     <= 1'b0;
      flood     <= 1'b0;
      drop_xc   <= 1'b0;
      vlan_mask <= `RFF_RST_VLAN;
      dump_mask <= `RFF_RST_DUMP;
      port_id   <= `RFF_RST_PORT;
    end else begin
      sw_rst <= 1'b0;
      if (reg_wr) begin
        if (reg_addr == `RFF_REG_CTRL) begin
          sw_rst  <= reg_wdata[`RFF_BIT_SWRST];
          stp_en  <= reg_wdata[`RFF_BIT_STP];
          ext_ar  <= reg_wdata[`RFF_BIT_EXTAR];
          port_id <= reg_wdata[12:8];
        end else if (reg_addr == `RFF_REG_OPT) begin
          xlong   <= reg_wdata[`RFF_BIT_XLONG];
          flood   <= reg_wdata[`RFF_BIT_FLOOD];
          drop_xc <= reg_wdata[`RFF_BIT_DROPXC];
        end else if (reg_addr == `RFF_REG_VLAN) begin
          vlan_mask <= reg_wdata[23:0];
        end else if (reg_addr == `RFF_REG_DUMP) begin
          dump_mask <= reg_wdata[23:0];
        end
      end
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0;
    end else if (reg_addr == `RFF_REG_CTRL) begin
      reg_rdata <= {19'h0, port_id, 5'h0, ext_ar, stp_en, 1'b0};
    end else if (reg_addr == `RFF_REG_OPT) begin
      reg_rdata <= {16'h0, drop_xc, 2'h0, flood, xlong, 11'h0};
    end else if (reg_addr == `RFF_REG_VLAN) begin
      reg_rdata <= {8'h0, vlan_mask};
    end else if (reg_addr == `RFF_REG_DUMP) begin
      reg_rdata <= {8'h0, dump_mask};
    end else if (reg_addr == `RFF_REG_STATUS) begin
      reg_rdata <= {frame_cnt, 7'h0, jabber_iso, 1'b0, last_err};
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Carrier length and jabber isolation.
  logic [15:0] car_bits;

  // Counts bit times of carrier, two per link edge, saturating.
  always_ff @(posedge clock) begin
    if (!rst_n || sw_rst) begin
      car_bits   <= 16'h0;
      jabber_iso <= 1'b0;
    end else if (link_edge) begin
      car_bits   <= !crs ? 16'h0 : (car_bits >= 16'hfffe) ? car_bits : car_bits + 16'h2;
      jabber_iso <= crs && (car_bits > `RFF_JABBER_BT);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address table: four entries, cleared only by the hardware reset.
  logic [3:0]  tbl_v;
  logic [47:0] tbl_mac [4];
  logic [4:0]  tbl_port [4];
  logic [3:0]  tbl_hit;
  logic [3:0]  sa_hit;
  logic [4:0]  hit_and [4];
  logic [1:0]  wr_ptr;
  logic [47:0] da;
  logic [47:0] sa;
  logic        learn_req;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_tbl
      assign tbl_hit[gi] = tbl_v[gi] && (tbl_mac[gi] == da);
      assign sa_hit[gi]  = tbl_v[gi] && (tbl_mac[gi] == sa);
      assign hit_and[gi] = tbl_hit[gi] ? tbl_port[gi] : 5'h0;
      // Learning refreshes a known address or fills the next slot.
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          tbl_v[gi]    <= 1'b0;
          tbl_mac[gi]  <= 48'h0;
          tbl_port[gi] <= 5'h0;
        end else if (learn_req && (sa_hit[gi] || (!(|sa_hit) && wr_ptr == gi))) begin
          tbl_v[gi]    <= 1'b1;
          tbl_mac[gi]  <= sa;
          tbl_port[gi] <= port_id;
        end
      end
    end
  endgenerate

  // Replacement pointer survives software reset with the table.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr <= 2'h0;
    end else if (learn_req && !(|sa_hit)) begin
      wr_ptr <= wr_ptr + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Forwarding decision from the captured addresses.
  logic        ext_got;
  logic        ext_hit;
  logic        ext_filt;
  logic [4:0]  ext_port;
  logic [23:0] src_bit;
  logic [23:0] next_mask;
  logic [4:0]  int_port;
  logic        dst_hit;
  logic [4:0]  dst_port;
  logic [23:0] dst_bit;
  logic        is_bpdu;

  assign src_bit = 24'h000001 << port_id;
  assign dst_bit = 24'h000001 << dst_port;
  assign is_bpdu = stp_en && (da == `RFF_BPDU_DA);

  // Picks table or resolver answer, then VLAN, flood and dumping rules.
  always_comb begin
    int_port = hit_and[0] | hit_and[1] | hit_and[2] | hit_and[3];
    dst_hit  = ext_ar ? (ext_got && ext_hit) : (|tbl_hit);
    dst_port = ext_ar ? ext_port : int_port;
    if (ext_ar && ext_got && ext_filt) begin
      next_mask = 24'h0;
    end else if (is_bpdu) begin
      next_mask = 24'h800000;
    end else if (da[40]) begin
      next_mask = vlan_mask & ~src_bit;
    end else if (dst_hit && dst_port == port_id) begin
      next_mask = 24'h0;
    end else if (dst_hit && |(dst_bit & vlan_mask)) begin
      next_mask = dst_bit;
    end else if (flood) begin
      next_mask = vlan_mask & ~src_bit;
    end else begin
      next_mask = dump_mask & ~src_bit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive state machine, CRC and frame checks.
  rff_state_e  state;
  logic [7:0]  win;
  logic [7:0]  shb;
  logic [1:0]  dib;
  logic [12:0] len;
  logic [15:0] typ;
  logic [31:0] crc;
  logic        jab_seen;
  logic [7:0]  next_win;
  logic [7:0]  next_byte;
  logic [12:0] next_len;
  logic [31:0] next_crc;
  rff_err_s    next_err;
  logic        next_pause;

  // One reflected CRC-32 step per bit, earliest bit of the dibit first.
  function automatic logic [31:0] crc_bit(input logic [31:0] c, input logic b);
    crc_bit = (c[0] ^ b) ? ((c >> 1) ^ `RFF_CRC_POLY) : (c >> 1);
  endfunction

  assign next_win  = {win[5:0], d[0], d[1]};
  assign next_byte = {d[1], d[0], shb[7:2]};
  assign next_len  = (len == 13'h1fff) ? len : len + 13'h1;
  assign next_crc  = crc_bit(crc_bit(crc, d[0]), d[1]);

  // Error set evaluated when carrier drops in the frame body.
  always_comb begin
    next_err           = '0;
    next_err.crc       = (crc != `RFF_CRC_RESID);
    next_err.align     = (dib != 2'h0);
    next_err.short_ev  = (car_bits < `RFF_SHORT_BT);
    next_err.runt      = ({len, 3'h0} < `RFF_RUNT_BT);
    next_err.long_ev   = len > (xlong ? `RFF_XMAX_LEN : `RFF_MAX_LEN);
    next_err.jabber    = jab_seen;
    next_pause         = (da == `RFF_PAUSE_DA) && (typ == `RFF_PAUSE_TYPE);
  end

  // Frame reception; all decisions leave in arrival order, one per frame.
  always_ff @(posedge clock) begin
    if (!rst_n || sw_rst) begin
      state         <= RFF_IDLE;
      win           <= 8'h0;
      shb           <= 8'h0;
      dib           <= 2'h0;
      len           <= 13'h0;
      typ           <= 16'h0;
      crc           <= `RFF_CRC_INIT;
      da            <= 48'h0;
      sa            <= 48'h0;
      jab_seen      <= 1'b0;
      rx_byte       <= 8'h0;
      rx_byte_valid <= 1'b0;
      stat_valid    <= 1'b0;
      stat_err      <= '0;
      stat_len      <= 13'h0;
      fwd_valid     <= 1'b0;
      fwd_mask      <= 24'h0;
      pause_seen    <= 1'b0;
      frame_err_led <= 1'b0;
      ar_req        <= '0;
      learn_req     <= 1'b0;
      frame_cnt     <= 16'h0;
      last_err      <= '0;
    end else begin
      rx_byte_valid   <= 1'b0;
      stat_valid      <= 1'b0;
      fwd_valid       <= 1'b0;
      pause_seen      <= 1'b0;
      frame_err_led   <= 1'b0;
      ar_req.da_valid <= 1'b0;
      ar_req.sa_valid <= 1'b0;
      ar_req.learn    <= 1'b0;
      learn_req       <= 1'b0;
      if (jabber_iso) begin
        jab_seen <= 1'b1;
      end
      if (link_edge) begin
        case (state)
          RFF_IDLE: begin
            if (crs) begin
              state    <= RFF_HUNT;
              win      <= {6'h0, d[0], d[1]};
              jab_seen <= 1'b0;
            end
          end
          RFF_HUNT: begin
            if (!crs) begin
              // Carrier without a delimiter is reported as false carrier.
              state              <= RFF_IDLE;
              stat_valid         <= 1'b1;
              stat_err           <= '0;
              stat_err.false_car <= 1'b1;
              stat_err.short_ev  <= (car_bits < `RFF_SHORT_BT);
              stat_len           <= 13'h0;
            end else begin
              win <= next_win;
              if (next_win == `RFF_SFD) begin
                state <= RFF_BODY;
                crc   <= `RFF_CRC_INIT;
                dib   <= 2'h0;
                len   <= 13'h0;
              end
            end
          end
          RFF_BODY: begin
            if (crs) begin
              crc <= next_crc;
              shb <= next_byte;
              dib <= dib + 2'h1;
              if (dib == 2'h3) begin
                rx_byte       <= next_byte;
                rx_byte_valid <= 1'b1;
                len           <= next_len;
                if (next_len <= 13'h6) begin
                  da <= {da[39:0], next_byte};
                end else if (next_len <= 13'hc) begin
                  sa <= {sa[39:0], next_byte};
                end else if (next_len <= 13'he) begin
                  typ <= {typ[7:0], next_byte};
                end
                if (next_len == 13'h6) begin
                  ar_req.da_valid <= 1'b1;
                  ar_req.da       <= {da[39:0], next_byte};
                end
                if (next_len == 13'hc) begin
                  ar_req.sa_valid <= 1'b1;
                  ar_req.sa       <= {sa[39:0], next_byte};
                end
              end
            end else begin
              state      <= RFF_IDLE;
              stat_valid <= 1'b1;
              stat_err   <= next_err;
              stat_len   <= len;
              last_err   <= next_err;
              frame_cnt  <= frame_cnt + 16'h1;
              if (|next_err) begin
                frame_err_led <= next_err.crc;
              end else if (next_pause) begin
                pause_seen <= 1'b1;
              end else begin
                fwd_valid    <= 1'b1;
                fwd_mask     <= next_mask;
                ar_req.learn <= 1'b1;
                learn_req    <= !ext_ar;
              end
            end
          end
          default: state <= RFF_IDLE;
        endcase
      end
    end
  end

  // Resolver answer held from frame start until the decision.
  always_ff @(posedge clock) begin
    if (!rst_n || sw_rst || state == RFF_IDLE) begin
      ext_got  <= 1'b0;
      ext_hit  <= 1'b0;
      ext_filt <= 1'b0;
      ext_port <= 5'h0;
    end else if (ar_rsp.valid) begin
      ext_got  <= 1'b1;
      ext_hit  <= ar_rsp.hit;
      ext_filt <= ar_rsp.filter;
      ext_port <= ar_rsp.port;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Excessive collision handling for the transmit side.
  logic [4:0] col_cnt;

  // At sixteen collisions the count restarts and the frame retries or drops.
  always_ff @(posedge clock) begin
    if (!rst_n || sw_rst) begin
      col_cnt  <= 5'h0;
      tx_retry <= 1'b0;
      tx_drop  <= 1'b0;
    end else begin
      tx_retry <= 1'b0;
      tx_drop  <= 1'b0;
      if (tx_done) begin
        col_cnt <= 5'h0;
      end else if (tx_col) begin
        if (col_cnt + 5'h1 == `RFF_EXCESS_COL) begin
          col_cnt  <= 5'h0;
          tx_retry <= !drop_xc;
          tx_drop  <= drop_xc;
        end else begin
          col_cnt <= col_cnt + 5'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n || sw_rst);

  sequence s_sfd_seen;
    link_edge && crs && state == RFF_HUNT && next_win == `RFF_SFD;
  endsequence
  sequence s_sixteenth_col;
    tx_col && !tx_done && col_cnt == 5'hf;
  endsequence

  a_sfd_to_body: assert property (s_sfd_seen |=> state == RFF_BODY && len == 13'h0)
    else $error("Delimiter did not open the frame body.");
  a_crc_led: assert property (stat_valid && stat_err.crc |-> frame_err_led && !fwd_valid)
    else $error("CRC error not signalled or frame forwarded.");
  a_err_nofwd: assert property (stat_valid && (|stat_err) |-> !fwd_valid)
    else $error("Error frame was forwarded.");
  a_no_self: assert property (fwd_valid && !is_bpdu |-> !fwd_mask[port_id])
    else $error("Frame sent back to its source port.");
  a_bpdu_cpu: assert property (fwd_valid && is_bpdu |-> fwd_mask == 24'h800000)
    else $error("Bridge frame not sent to the CPU port only.");
  a_mcast_vlan: assert property (fwd_valid && da[40] && !is_bpdu
                                 |-> fwd_mask == (vlan_mask & ~src_bit))
    else $error("Group frame not sent to the source VLAN.");
  a_runt_len: assert property (stat_valid && !stat_err.false_car && stat_len < 13'h40
                               |-> stat_err.runt)
    else $error("Short frame not flagged as runt.");
  a_jabber_iso: assert property (link_edge && crs && car_bits > `RFF_JABBER_BT
                                 |=> jabber_iso)
    else $error("Jabbering port not isolated.");
  a_jabber_free: assert property (link_edge && !crs |=> !jabber_iso)
    else $error("Isolation held after carrier stopped.");
  a_excess_col: assert property (s_sixteenth_col |=> col_cnt == 5'h0 && (tx_drop == drop_xc)
                                 && (tx_retry != drop_xc))
    else $error("Excessive collision not handled.");
  a_learn_good: assert property (fwd_valid |-> ar_req.learn ##1 !ar_req.learn)
    else $error("Good frame did not learn its source.");

endmodule // rff_top

// ---- rff_phy_model.sv ----
`timescale 1ns/1ps
module rff_phy_model (
  // Reduced MII receive pins.
  output logic       rx_clk,
  output logic       crs_dv,
  output logic [1:0] rxd
);
  // Pins start low; after a frame crs_dv stays low while the link clock runs 40 more periods with rxd toggling.
  initial begin
    rx_clk = 1'b0;
    crs_dv = 1'b0;
    rxd    = 2'b00;
  end
  // One link period of 400 ns; data change just after the falling edge.
  task automatic tick();
    #200 rx_clk = 1'b1;
    #200 rx_clk = 1'b0;
  endtask
  // Sends preamble, delimiter and body, two bits per edge, low bits first.
  task automatic send(input logic [7:0] b[$], input int pre);
    #17;
    crs_dv = 1'b1;
    repeat (pre) begin
      rxd = 2'b01;
      tick();
    end
    rxd = 2'b11;
    tick();
    foreach (b[i]) for (int k = 0; k < 4; k++) begin
      rxd = b[i][2*k+:2];
      tick();
    end
    crs_dv = 1'b0;
    // The released data line toggles so no stale value reads as data.
    repeat (40) begin
      rxd = ~rxd;
      tick();
    end
  endtask
endmodule // rff_phy_model

// ---- rff_top_bench.sv ----
`timescale 1ns/1ps
`include "rff_cfg.svh"
module rff_top_bench;
  import rff_pkg::*;
  logic clock, rst_n, rx_clk, crs_dv, reg_wr, reg_rd, rx_byte_valid, stat_valid;
  logic fwd_valid, pause_seen, frame_err_led, jabber_iso, tx_col, tx_done, tx_retry, tx_drop;
  logic [1:0] rxd;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] rx_byte, last_byte;
  logic [12:0] stat_len, last_len;
  logic [23:0] fwd_mask, last_mask;
  logic [6:0] last_err;
  rff_err_s stat_err;
  rff_ar_req_s ar_req;
  rff_ar_rsp_s ar_rsp;
  int error_cnt, checks_done, st_cnt, fw_cnt, led_cnt, rt_cnt, dr_cnt, by_cnt, ps_cnt;
  localparam logic [47:0] BC = 48'hffffffffffff, SA1 = 48'h020000000001;
  localparam logic [47:0] SA2 = 48'h020000000002, UNK = 48'h020000000009;

  rff_phy_model phy (.rx_clk(rx_clk), .crs_dv(crs_dv), .rxd(rxd));
  rff_top uut (.clock(clock), .rst_n(rst_n), .rx_clk(rx_clk), .crs_dv(crs_dv), .rxd(rxd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
    .stat_valid(stat_valid), .stat_err(stat_err), .stat_len(stat_len),
    .fwd_valid(fwd_valid), .fwd_mask(fwd_mask), .pause_seen(pause_seen),
    .frame_err_led(frame_err_led), .jabber_iso(jabber_iso), .ar_req(ar_req),
    .ar_rsp(ar_rsp), .tx_col(tx_col), .tx_done(tx_done), .tx_retry(tx_retry),
    .tx_drop(tx_drop));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 50 ns period.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Records reported frames, delivered masks and single-cycle pulses.
  always @(posedge clock) begin
    if (stat_valid === 1'b1) begin
      st_cnt++;
      last_err = stat_err;
      last_len = stat_len;
    end
    if (fwd_valid === 1'b1 && fwd_mask !== 24'h000000) begin
      fw_cnt++;
      last_mask = fwd_mask;
    end
    if (frame_err_led === 1'b1) led_cnt++;
    if (tx_retry === 1'b1) rt_cnt++;
    if (tx_drop === 1'b1) dr_cnt++;
    if (pause_seen === 1'b1) ps_cnt++;
    if (rx_byte_valid === 1'b1) begin
      by_cnt++;
      last_byte = rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the comparison.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Register write and read on the plain port.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
  endtask
  // Reflected CRC over a byte list, returned inverted as sent on the wire.
  function automatic logic [31:0] crc(input logic [7:0] q[$]);
    logic [31:0] c;
    c = `RFF_CRC_INIT;
    foreach (q[i]) for (int k = 0; k < 8; k++)
      c = (c[0] ^ q[i][k]) ? (c >> 1) ^ `RFF_CRC_POLY : c >> 1;
    return ~c;
  endfunction
  // Builds, sends and checks one frame; frames under 18 bytes carry only a check field.
  task automatic run(input logic [47:0] da, input logic [47:0] sa, input int n, input bit bad,
                     input int pre, input logic [6:0] ee, input int ef, input logic [23:0] em);
    int s0, f0, l0, b0;
    logic [7:0] q[$];
    logic [31:0] c;
    s0 = st_cnt;
    f0 = fw_cnt;
    l0 = led_cnt;
    b0 = by_cnt;
    if (n >= 18) begin
      for (int i = 5; i >= 0; i--) q.push_back(da[8*i+:8]);
      for (int i = 5; i >= 0; i--) q.push_back(sa[8*i+:8]);
      q.push_back(da == `RFF_PAUSE_DA ? 8'h88 : 8'h08);
      q.push_back(da == `RFF_PAUSE_DA ? 8'h08 : 8'h00);
      while (q.size() < n - 4) q.push_back(8'(q.size()));
    end
    c = crc(q);
    for (int i = 0; i < 4; i++) q.push_back(c[8*i+:8] ^ {7'h00, bad});
    phy.send(q, pre);
    repeat (20) @(posedge clock);
    check(32'(st_cnt - s0), 32'h1);
    check(32'(last_err), 32'(ee));
    check(32'(last_len), 32'(n));
    check(32'(fw_cnt - f0), 32'(ef));
    check(32'(led_cnt - l0), 32'(bad));
    check(32'(by_cnt - b0), 32'(n));
    check(32'(last_byte), 32'(q[q.size() - 1]));
    check(32'(last_mask), 32'(em));
    $display("frame test of %0d bytes done", n);
  endtask
  // Sixteen collisions after a completed transmission.
  task automatic coll(input int er, input int ed);
    @(posedge clock) tx_done <= 1'b1;
    @(posedge clock) tx_done <= 1'b0;
    repeat (16) begin
      @(posedge clock) tx_col <= 1'b1;
      @(posedge clock) tx_col <= 1'b0;
    end
    repeat (4) @(posedge clock);
    check(32'(rt_cnt), 32'(er));
    check(32'(dr_cnt), 32'(ed));
    $display("collision test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {rst_n, reg_wr, reg_rd, tx_col, tx_done} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    ar_rsp = '0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd(`RFF_REG_VLAN, 32'h00ffffff);
    rd(`RFF_REG_DUMP, 32'h00000000);
    rd(5'h1c, 32'h00000000);
    $display("register test done");
    run(BC, SA1, 64, 0, 16, 7'h00, 1, 24'hfffffe);
    run(BC, SA1, 64, 1, 7, 7'h01, 0, 24'hfffffe);
    run(SA1, SA2, 64, 0, 16, 7'h00, 0, 24'hfffffe);
    wr(`RFF_REG_CTRL, 32'h00000101);
    run(SA1, SA2, 70, 0, 16, 7'h00, 1, 24'h000001);
    wr(`RFF_REG_DUMP, 32'h00000010);
    run(UNK, SA2, 64, 0, 16, 7'h00, 1, 24'h000010);
    wr(`RFF_REG_OPT, 32'h00001000);
    run(UNK, SA2, 64, 0, 16, 7'h00, 1, 24'hfffffd);
    wr(`RFF_REG_CTRL, 32'h00000102);
    run(`RFF_BPDU_DA, SA2, 64, 0, 16, 7'h00, 1, 24'h800000);
    run(`RFF_PAUSE_DA, SA2, 64, 0, 16, 7'h00, 0, 24'h800000);
    check(32'(ps_cnt), 32'h1);
    run(BC, SA2, 4, 0, 4, 7'h18, 0, 24'h800000);
    run(BC, SA2, 1519, 0, 16, 7'h20, 0, 24'h800000);
    wr(`RFF_REG_CTRL, 32'h00000106);
    @(posedge clock) ar_rsp <= 8'hc5;
    run(UNK, SA2, 64, 0, 16, 7'h00, 1, 24'h000020);
    check(ar_req.da[31:0], UNK[31:0]);
    check(ar_req.sa[31:0], SA2[31:0]);
    @(posedge clock) ar_rsp <= 8'he5;
    run(UNK, SA2, 64, 0, 16, 7'h00, 0, 24'h000020);
    @(posedge clock) ar_rsp <= '0;
    coll(1, 0);
    wr(`RFF_REG_OPT, 32'h00009000);
    coll(1, 1);
    rd(`RFF_REG_STATUS, 32'h00090000);
    rd(`RFF_REG_CTRL, 32'h00000106);
    rd(`RFF_REG_OPT, 32'h00009000);
    results();
  end
  // Cuts a hang short at 5 ms, about a third beyond the expected run time of some 3.7 ms.
  initial begin
    #5000000;
    error_cnt++;
    results();
  end
endmodule // rff_top_bench
